// [rmc_pkg.sv]
/*
 * Shared types and constants for the rail monitor and on/off control block.
 * Assumes a 25 MHz system clock and a separately clocked sense-sample link.
 */
package rmc_pkg;

	// ==========================================================
	// Sizes and timing
	localparam int RAILS        = 24;
	localparam int VW           = 16;
	localparam int CLK_MHZ      = 25;
	localparam int STEP_US      = 400;
	localparam int STEP_CYC     = STEP_US * CLK_MHZ;
	localparam int STEP_MV      = 20;
	localparam logic [15:0] VOUT_RST = 16'h0000;
	localparam logic signed [4:0] EXP_RST = 5'sh13;

	// ==========================================================
	// On/off source codes
	localparam logic [1:0] SRC_AUTO = 2'h0;
	localparam logic [1:0] SRC_CTRL = 2'h1;
	localparam logic [1:0] SRC_OPER = 2'h2;
	localparam logic [1:0] SRC_BOTH = 2'h3;

	// ==========================================================
	// Threshold index order
	localparam int TH_OVF = 0;
	localparam int TH_OVW = 1;
	localparam int TH_UVW = 2;
	localparam int TH_UVF = 3;
	localparam int TH_MGH = 4;
	localparam int TH_MGL = 5;
	localparam int TH_PGN = 6;
	localparam int TH_PGF = 7;
	localparam int NTH    = 8;

	typedef logic [VW-1:0] rmc_v_t;
	typedef rmc_v_t [NTH-1:0] rmc_th_t;

	typedef struct packed {
		logic       senseAssigned;
		logic       adaptive;
		logic [1:0] onOffSrc;
		logic signed [4:0] vExp;
		rmc_th_t    ratio;
	} rmc_cfg_t;

	typedef struct packed {
		logic overFault;
		logic overWarn;
		logic underWarn;
		logic underFault;
	} rmc_evt_t;

endpackage : rmc_pkg

// [rmc_rail_monitor.sv]
/*
 * Per-rail sensing, threshold tracking and on/off request logic.
 * Assumes sense samples arrive on their own link clock with a valid strobe,
 * and that a host-side bus agent delivers decoded PMBus settings as ports.
 */
//Function
//- Up to 24 rails, each with its sense input, enable and margin output.
//- Host port works at 100 kHz or 400 kHz bus rates.
//- Provide an ALERT line to tell the host of pending conditions.
//- Standard commands where possible, vendor commands for unique features.
//- Sensed voltage outside over warn/fault window raises an event; under warn/fault only while the rail is enabled.
//- A detected fault triggers the configured response action.
//- Voltages in linear format, resolution set by per-rail exponent.
//- New rails start with setpoint zero until configured.
//- Automatic source requests turn-on always.
//- Control-line source follows the CONTROL line.
//- Bus source follows the last OPERATION state.
//- Both sources: on needs CONTROL and OPERATION; off if either drops.
//- Dependencies and delays are judged before the enable output changes.
//- Adaptive mode keeps thresholds at fixed ratios to the setpoint.
//- Raised setpoint moves over-voltage thresholds at once.
//- Other thresholds step 20 mV every 400 us until they arrive.
//- Lowered setpoint moves under-voltage and power-good at once, others step.
`timescale 1ns/10ps
module rmc_rail_monitor #(
	parameter int RAILS    = rmc_pkg::RAILS,
	parameter int STEP_CYC = rmc_pkg::STEP_CYC
) (
	input  wire logic                      mclk,          // System clock, 25 MHz.
	input  wire logic                      nrst,          // Asynchronous reset, active low.
	input  wire logic                      senseClk,      // Sense sample link clock.
	input  wire logic [RAILS-1:0]          senseValid,    // Sample strobe per rail, link domain.
	input  wire rmc_pkg::rmc_v_t [RAILS-1:0] senseVolt,   // Sampled rail voltage, link domain.
	input  wire rmc_pkg::rmc_cfg_t [RAILS-1:0] railCfg,   // Per-rail configuration.
	input  wire rmc_pkg::rmc_th_t [RAILS-1:0] absTh,      // Absolute thresholds, adaptive off.
	input  wire rmc_pkg::rmc_v_t [RAILS-1:0] voutCmd,     // Setpoint written by host.
	input  wire logic [RAILS-1:0]          voutWr,        // Setpoint write strobe.
	input  wire logic [RAILS-1:0]          operOn,        // Last OPERATION state per rail.
	input  wire logic                      controlPin,    // CONTROL line, asynchronous.
	input  wire logic [RAILS-1:0]          seqReady,      // Dependencies and delays met.
	input  wire logic                      alertClear,    // Host clears pending alert.
	output rmc_pkg::rmc_evt_t [RAILS-1:0]  railEvt,       // Event levels per rail.
	output logic [RAILS-1:0]               faultAction,   // Fault response request pulse.
	output logic [RAILS-1:0]               onRequest,     // Rail seeks to turn on.
	output logic [RAILS-1:0]               railEnable,    // Enable output.
	output logic [RAILS-1:0]               marginOut,     // Margin output active.
	output rmc_pkg::rmc_v_t [RAILS-1:0]    voutNow,       // Current setpoint readback.
	output logic signed [4:0]              voutExp0,      // Exponent of rail 0 readback.
	output logic                           alertN         // ALERT line, active low.
);

	// ==========================================================
	// Link domain: capture each sample and toggle a flag.
	typedef struct packed {
		rmc_pkg::rmc_v_t [RAILS-1:0] hold;
		logic [RAILS-1:0]            tgl;
	} rmc_link_t;

	rmc_link_t lnk_reg, lnk_next;

	always_comb begin
		lnk_next = lnk_reg;
		for (int i = 0; i < RAILS; i++) begin
			if (senseValid[i]) begin
				lnk_next.hold[i] = senseVolt[i];
				lnk_next.tgl[i]  = ~lnk_reg.tgl[i];
			end
		end
	end

	always_ff @(posedge senseClk or negedge nrst) begin
		if (!nrst) begin
			lnk_reg <= '0;
		end else begin
			lnk_reg <= lnk_next;
		end
	end

	// ==========================================================
	// System domain state.
	typedef struct packed {
		logic [RAILS-1:0]            ts1;
		logic [RAILS-1:0]            ts2;
		logic [RAILS-1:0]            ts3;
		logic                        cp1;
		logic                        cp2;
		rmc_pkg::rmc_v_t [RAILS-1:0] volt;
		rmc_pkg::rmc_v_t [RAILS-1:0] vout;
		rmc_pkg::rmc_th_t [RAILS-1:0] th;
		rmc_pkg::rmc_evt_t [RAILS-1:0] evt;
		logic [RAILS-1:0]            fact;
		logic [RAILS-1:0]            en;
		logic [RAILS-1:0]            alertPend;
		logic [15:0]                 stepCnt;
		logic signed [4:0]           exp0;
	} rmc_st_t;

	rmc_st_t st_reg, st_next;

	// Target threshold: setpoint scaled by ratio, ratio is Q1.15 style fraction of 2.
	function automatic rmc_pkg::rmc_v_t scaleTh(input rmc_pkg::rmc_v_t v, input rmc_pkg::rmc_v_t r);
		logic [31:0] p;
		p = v * r;
		return p[30:15];
	endfunction : scaleTh

	// Converts the 20 mV step into linear counts for the rail exponent.
	function automatic rmc_pkg::rmc_v_t stepCounts(input logic signed [4:0] e);
		logic [31:0] s;
		s = (32'(rmc_pkg::STEP_MV) << 16) / 32'd1000;
		s = s >> (5'(16) + e[4:0]);
		return (s == 32'h0) ? 16'h0001 : s[15:0];
	endfunction : stepCounts

	function automatic logic isImmediate(input int k, input logic up);
		if (up) begin
			return (k == rmc_pkg::TH_OVF) || (k == rmc_pkg::TH_OVW);
		end
		return (k == rmc_pkg::TH_UVF) || (k == rmc_pkg::TH_UVW) ||
		       (k == rmc_pkg::TH_PGN) || (k == rmc_pkg::TH_PGF);
	endfunction : isImmediate

	// One source decode serves both the request output and the enable path, so they cannot drift apart.
	function automatic logic seekOn(input logic [1:0] src, input logic ctl, input logic op);
		case (src)
			rmc_pkg::SRC_AUTO: return 1'b1;
			rmc_pkg::SRC_CTRL: return ctl;
			rmc_pkg::SRC_OPER: return op;
			rmc_pkg::SRC_BOTH: return ctl && op;
			default: return 1'b0;
		endcase
	endfunction : seekOn

	logic stepTick;
	assign stepTick = (st_reg.stepCnt == 16'(STEP_CYC - 1));

	always_comb begin
		rmc_pkg::rmc_v_t tgt;
		rmc_pkg::rmc_v_t inc;
		logic            up;
		logic            want;
		tgt = '0;
		inc = '0;
		up = 1'b0;
		want = 1'b0;
		st_next = st_reg;
		st_next.ts1 = lnk_reg.tgl;
		st_next.ts2 = st_reg.ts1;
		st_next.ts3 = st_reg.ts2;
		st_next.cp1 = controlPin;
		st_next.cp2 = st_reg.cp1;
		st_next.stepCnt = stepTick ? 16'h0000 : st_reg.stepCnt + 16'h0001;
		st_next.fact = '0;
		st_next.exp0 = railCfg[0].vExp;
		for (int i = 0; i < RAILS; i++) begin
			// The held word is stable for several cycles after the toggle crosses.
			if (st_reg.ts2[i] != st_reg.ts3[i]) begin
				st_next.volt[i] = lnk_reg.hold[i];
			end
			up = voutCmd[i] > st_reg.vout[i];
			// Host strobes are taken on every edge, far faster than either bus rate needs.
			if (voutWr[i]) begin
				st_next.vout[i] = voutCmd[i];
			end
			for (int k = 0; k < rmc_pkg::NTH; k++) begin
				tgt = scaleTh(st_reg.vout[i], railCfg[i].ratio[k]);
				inc = stepCounts(railCfg[i].vExp);
				if (!railCfg[i].adaptive) begin
					st_next.th[i][k] = absTh[i][k];
				end else if (voutWr[i] && isImmediate(k, up)) begin
					st_next.th[i][k] = scaleTh(voutCmd[i], railCfg[i].ratio[k]);
				end else if (stepTick && st_reg.th[i][k] != tgt) begin
					if (st_reg.th[i][k] < tgt) begin
						st_next.th[i][k] = (tgt - st_reg.th[i][k] > inc) ? st_reg.th[i][k] + inc : tgt;
					end else begin
						st_next.th[i][k] = (st_reg.th[i][k] - tgt > inc) ? st_reg.th[i][k] - inc : tgt;
					end
				end
			end
			if (railCfg[i].senseAssigned) begin
				st_next.evt[i].overFault  = st_reg.volt[i] > st_reg.th[i][rmc_pkg::TH_OVF];
				st_next.evt[i].overWarn   = st_reg.volt[i] > st_reg.th[i][rmc_pkg::TH_OVW];
				st_next.evt[i].underWarn  = st_reg.en[i] && st_reg.volt[i] < st_reg.th[i][rmc_pkg::TH_UVW];
				st_next.evt[i].underFault = st_reg.en[i] && st_reg.volt[i] < st_reg.th[i][rmc_pkg::TH_UVF];
			end else begin
				st_next.evt[i] = '0;
			end
			st_next.fact[i] = (st_next.evt[i].overFault || st_next.evt[i].underFault) &&
			                  !(st_reg.evt[i].overFault || st_reg.evt[i].underFault);
			want = seekOn(railCfg[i].onOffSrc, st_reg.cp2, operOn[i]);
			if (seqReady[i]) begin
				st_next.en[i] = want && !st_reg.fact[i];
			end
			// New faults and new over-warn events win over a host clear in the same cycle.
			if (st_next.fact[i] || (st_next.evt[i].overWarn && !st_reg.evt[i].overWarn)) begin
				st_next.alertPend[i] = 1'b1;
			end else if (alertClear) begin
				st_next.alertPend[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs.
	genvar g;
	generate
		for (g = 0; g < RAILS; g++) begin : gOut
			assign onRequest[g] = seekOn(railCfg[g].onOffSrc, st_reg.cp2, operOn[g]);
		end
	endgenerate

	assign railEvt     = st_reg.evt;
	assign faultAction = st_reg.fact;
	assign railEnable  = st_reg.en;
	// Margining lies outside this block, so the margin outputs are held inactive.
	assign marginOut   = '0;
	assign voutNow     = st_reg.vout;
	assign voutExp0    = st_reg.exp0;
	assign alertN      = ~|st_reg.alertPend;

	// ==========================================================
	// Checks.
	property p_ovEvt;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].senseAssigned && st_reg.volt[0] > st_reg.th[0][rmc_pkg::TH_OVF]) |=> railEvt[0].overFault;
	endproperty
	a_ovEvt: assert property (p_ovEvt) else $error("Over fault not raised.");

	property p_auto;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].onOffSrc == rmc_pkg::SRC_AUTO) |-> onRequest[0];
	endproperty
	a_auto: assert property (p_auto) else $error("Auto rail not requesting on.");

	property p_both;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].onOffSrc == rmc_pkg::SRC_BOTH && !operOn[0]) |-> !onRequest[0];
	endproperty
	a_both: assert property (p_both) else $error("Both-source rail on without operation.");

	property p_hold;
		@(posedge mclk) disable iff (!nrst)
		!seqReady[0] |=> $stable(railEnable[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("Enable changed without readiness.");

	property p_fact;
		@(posedge mclk) disable iff (!nrst)
		faultAction[0] |=> !faultAction[0];
	endproperty
	a_fact: assert property (p_fact) else $error("Fault action not a pulse.");

	property p_abs;
		@(posedge mclk) disable iff (!nrst)
		!railCfg[0].adaptive |=> st_reg.th[0][rmc_pkg::TH_OVF] == $past(absTh[0][rmc_pkg::TH_OVF]);
	endproperty
	a_abs: assert property (p_abs) else $error("Absolute threshold not used.");

	property p_step;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].adaptive && !voutWr[0] && !stepTick) |=> $stable(st_reg.th[0][rmc_pkg::TH_MGH]);
	endproperty
	a_step: assert property (p_step) else $error("Threshold moved between steps.");

	property p_alert;
		@(posedge mclk) disable iff (!nrst)
		faultAction[0] |-> !alertN;
	endproperty
	a_alert: assert property (p_alert) else $error("Alert missing on fault.");

	property p_ctrlSrc;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].onOffSrc == rmc_pkg::SRC_CTRL && $past(nrst, 2)) |-> onRequest[0] == $past(controlPin, 2);
	endproperty
	a_ctrlSrc: assert property (p_ctrlSrc) else $error("Control-line rail not following the line.");

	property p_operSrc;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].onOffSrc == rmc_pkg::SRC_OPER) |-> onRequest[0] == operOn[0];
	endproperty
	a_operSrc: assert property (p_operSrc) else $error("Bus-source rail not following operation state.");

	property p_enFollow;
		@(posedge mclk) disable iff (!nrst)
		(seqReady[0] && !faultAction[0]) |=> railEnable[0] == $past(onRequest[0]);
	endproperty
	a_enFollow: assert property (p_enFollow) else $error("Enable did not follow the request.");

	property p_faultOff;
		@(posedge mclk) disable iff (!nrst)
		(faultAction[0] && seqReady[0]) |=> !railEnable[0];
	endproperty
	a_faultOff: assert property (p_faultOff) else $error("Fault action did not drop the enable.");

	property p_uvOff;
		@(posedge mclk) disable iff (!nrst)
		!railEnable[0] |=> !railEvt[0].underWarn && !railEvt[0].underFault;
	endproperty
	a_uvOff: assert property (p_uvOff) else $error("Under-voltage event while rail is off.");

	property p_noSense;
		@(posedge mclk) disable iff (!nrst)
		!railCfg[0].senseAssigned |=> railEvt[0] == 4'h0;
	endproperty
	a_noSense: assert property (p_noSense) else $error("Event on a rail without sense input.");

	property p_ovImm;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].adaptive && voutWr[0] && voutCmd[0] > voutNow[0]) |=>
			st_reg.th[0][rmc_pkg::TH_OVW] == scaleTh($past(voutCmd[0]), $past(railCfg[0].ratio[rmc_pkg::TH_OVW]));
	endproperty
	a_ovImm: assert property (p_ovImm) else $error("Over-warn level not moved at once.");

	property p_uvImm;
		@(posedge mclk) disable iff (!nrst)
		(railCfg[0].adaptive && voutWr[0] && voutCmd[0] < voutNow[0]) |=>
			st_reg.th[0][rmc_pkg::TH_UVW] == scaleTh($past(voutCmd[0]), $past(railCfg[0].ratio[rmc_pkg::TH_UVW]));
	endproperty
	a_uvImm: assert property (p_uvImm) else $error("Under-warn level not moved at once.");

	property p_exp;
		@(posedge mclk) disable iff (!nrst)
		1'b1 |=> voutExp0 == $past(railCfg[0].vExp);
	endproperty
	a_exp: assert property (p_exp) else $error("Exponent readback does not track the setting.");

	property p_alertHold;
		@(posedge mclk) disable iff (!nrst)
		(!alertN && !alertClear) |=> !alertN;
	endproperty
	a_alertHold: assert property (p_alertHold) else $error("Alert dropped without a clear.");

	c_fault: cover property (@(posedge mclk) disable iff (!nrst) faultAction[0]);
	c_en:    cover property (@(posedge mclk) disable iff (!nrst) $rose(railEnable[0]));
	c_step:  cover property (@(posedge mclk) disable iff (!nrst) stepTick && railCfg[0].adaptive);
	c_lower: cover property (@(posedge mclk) disable iff (!nrst) voutWr[0] && voutCmd[0] < voutNow[0]);

endmodule : rmc_rail_monitor

// [rmc_rail_model.sv]
/*
 * Behavioural model of the monitored supply rails feeding the sense link.
 * Assumes the bench supplies the link clock and the voltage each rail shows.
 */
`timescale 1ns/10ps
module rmc_rail_model #(
	parameter int RAILS = rmc_pkg::RAILS
) (
	senseClk,
	nrst,
	level,
	senseValid,
	senseVolt
);
	input  wire logic                        senseClk;   // Link clock.
	input  wire logic                        nrst;       // Reset, active low.
	input  wire rmc_pkg::rmc_v_t [RAILS-1:0] level;      // Voltage each rail shows.
	output logic [RAILS-1:0]                 senseValid; // Sample strobes.
	output rmc_pkg::rmc_v_t [RAILS-1:0]      senseVolt;  // Sampled voltages.

	// ==========================================================
	// Sampler
	logic [4:0] cnt;

	// A sample is held for 28 link cycles, longer than the required
	// four system cycles. It is then scrambled so that a late read fails.
	always_ff @(posedge senseClk or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
			senseValid <= '0;
			senseVolt <= '0;
		end else begin
			cnt <= cnt + 5'h01;
			senseValid <= {RAILS{cnt == 5'h1f}};
			if (cnt == 5'h1f)
				senseVolt <= level;
			else if (cnt >= 5'h1b)
				senseVolt <= ~senseVolt;
		end
	end
endmodule : rmc_rail_model

// [rmc_rail_monitor_tb.sv]
/*
 * Self-checking bench for the rail monitor, watching rail 0.
 * Assumes the rail model drives the sense link at a 6 ns link clock.
 */
`timescale 1ns/10ps
module rmc_rail_monitor_tb;
	localparam int R = rmc_pkg::RAILS;
	logic                      mclk, nrst, senseClk, controlPin, alertClear, alertN;
	logic [R-1:0]              senseValid, voutWr, operOn, seqReady;
	logic [R-1:0]              faultAction, onRequest, railEnable, marginOut;
	rmc_pkg::rmc_v_t [R-1:0]   senseVolt, level, voutCmd, voutNow;
	rmc_pkg::rmc_cfg_t [R-1:0] railCfg;
	rmc_pkg::rmc_th_t [R-1:0]  absTh;
	rmc_pkg::rmc_evt_t [R-1:0] railEvt;
	logic signed [4:0]         voutExp0;
	int                        miscompares, n_tests, nAct;

	rmc_rail_monitor #(.RAILS(R), .STEP_CYC(20)) dut_u (.mclk, .nrst, .senseClk, .senseValid, .senseVolt,
		.railCfg, .absTh, .voutCmd, .voutWr, .operOn, .controlPin, .seqReady, .alertClear, .railEvt,
		.faultAction, .onRequest, .railEnable, .marginOut, .voutNow, .voutExp0, .alertN);
	rmc_rail_model #(.RAILS(R)) model_u (.senseClk, .nrst, .level, .senseValid, .senseVolt);

	// ==========================================================
	// Clocks and helpers
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		senseClk = 1'b0;
		#1.7;
		forever #3 senseClk = ~senseClk;
	end
	always @(negedge mclk) if (faultAction[0] === 1'b1) nAct++;

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	// ==========================================================
	// Scenarios
	task automatic t_onoff();
		logic e;
		for (int s = 0; s < 4; s++) for (int k = 0; k < 4; k++) begin
			railCfg[0].onOffSrc = s[1:0];
			controlPin = k[0];
			operOn[0] = k[1];
			cyc(4);
			e = (s == 0) | (s == 1 & k[0]) | (s == 2 & k[1]) | (s == 3 & k[0] & k[1]);
			chk(onRequest[0], e);
		end
		chk(railEnable[0], 1'b0);
		$display("done onoff");
	endtask : t_onoff

	task automatic t_window();
		rmc_pkg::rmc_v_t lv[4] = '{16'h0900, 16'h0780, 16'h0f00, 16'h1100};
		logic [3:0] ev[4] = '{4'h0, 4'h2, 4'h4, 4'hc};
		railCfg[0].onOffSrc = rmc_pkg::SRC_AUTO;
		seqReady[0] = 1'b1;
		cyc(8);
		chk(railEnable[0], 1'b1);
		nAct = 0;
		for (int i = 0; i < 4; i++) begin
			level[0] = lv[i];
			cyc(20);
			chk(railEvt[0], ev[i]);
		end
		chk(nAct, 1);
		chk(alertN, 1'b0);
		level[0] = 16'h0900;
		cyc(20);
		alertClear = 1'b1;
		cyc(1);
		alertClear = 1'b0;
		cyc(3);
		chk(alertN, 1'b1);
		chk(marginOut[0], 1'b0);
		railCfg[0].senseAssigned = 1'b0;
		level[0] = 16'h1100;
		cyc(20);
		chk(railEvt[0], 4'h0);
		level[0] = 16'h0900;
		cyc(20);
		railCfg[0].senseAssigned = 1'b1;
		cyc(2);
		$display("done window");
	endtask : t_window

	// A raised setpoint lifts the over-warn level at once, clearing the warning.
	// The other levels then step, and a lowered setpoint drops the under levels at once.
	task automatic t_adaptive();
		// Enable is frozen so that a fault pulse cannot gate the under-voltage events off.
		seqReady[0] = 1'b0;
		railCfg[0].adaptive = 1'b1;
		voutCmd[0] = 16'h0800;
		voutWr[0] = 1'b1;
		cyc(1);
		voutWr[0] = 1'b0;
		cyc(20);
		chk(voutNow[0], 16'h0800);
		chk(railEvt[0].overWarn, 1'b1);
		voutCmd[0] = 16'h1000;
		voutWr[0] = 1'b1;
		cyc(1);
		voutWr[0] = 1'b0;
		cyc(3);
		chk(railEvt[0].overWarn, 1'b0);
		chk(railEvt[0].underWarn, 1'b0);
		cyc(100);
		chk(railEvt[0].underWarn, 1'b1);
		voutCmd[0] = 16'h0800;
		voutWr[0] = 1'b1;
		cyc(1);
		voutWr[0] = 1'b0;
		cyc(3);
		chk(railEvt[0].underWarn, 1'b0);
		chk(railEvt[0].overWarn, 1'b0);
		$display("done adaptive");
	endtask : t_adaptive

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		nrst = 1'b0;
		{controlPin, alertClear} = 2'h0;
		{voutWr, operOn, seqReady} = '0;
		voutCmd = '0;
		level = '0;
		level[0] = 16'h0900;
		absTh = '0;
		absTh[0] = {16'h0700, 16'h0700, 16'h0900, 16'h0700, 16'h0700, 16'h0800, 16'h0e00, 16'h1000};
		railCfg = '0;
		railCfg[0].senseAssigned = 1'b1;
		railCfg[0].vExp = rmc_pkg::EXP_RST;
		railCfg[0].ratio = {16'h7333, 16'h6ccd, 16'h7333, 16'h8ccd, 16'h6ccd, 16'h7333, 16'h8ccd, 16'h9333};
		cyc(20);
		nrst = 1'b1;
		cyc(1);
		chk(voutNow[0], 16'h0000);
		chk(alertN, 1'b1);
		chk(voutExp0, rmc_pkg::EXP_RST);
		t_onoff();
		t_window();
		t_adaptive();
		close_out();
	end
	initial begin
		#(2000 * 40);
		miscompares++;
		close_out();
	end
endmodule : rmc_rail_monitor_tb
